// ==== common/nibble_alu_pkg.sv ====
// shared constants, types and register map of the nibble ALU
package nibble_alu_pkg;

  // ------------------------------------------------------------
  // register map (word indices, byte address = 4 * index)
  // ------------------------------------------------------------
  localparam int          ADDR_W           = 12;
  localparam logic [9:0]  IDX_COMMAND      = 10'h000;
  localparam logic [9:0]  IDX_RESULT       = 10'h001;
  localparam logic [9:0]  IDX_STATUS       = 10'h07F;
  localparam logic [6:0]  STATUS_DATA_ADDR = 7'h7F;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [3:0]  STATUS_RESET     = 4'h0;
  localparam logic [31:0] COMMAND_RESET    = 32'h0000_0000;
  localparam logic [3:0]  RESULT_RESET     = 4'h0;

  // ------------------------------------------------------------
  // decimal adjustment constants
  // ------------------------------------------------------------
  localparam logic [3:0]  DEC_MAX_DIGIT    = 4'h9;
  localparam logic [3:0]  DEC_FIX          = 4'h6;
  localparam logic [3:0]  DEC_BAD_DIGIT    = 4'hA;
  localparam logic [3:0]  DEC_ADD_TOP      = 4'h3;
  localparam logic [3:0]  DEC_SUB_LOW      = 4'h6;

  // ------------------------------------------------------------
  // operation codes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_ADD                      = 4'h0,
    OP_ADD_WITH_CARRY           = 4'h1,
    OP_SUB                      = 4'h2,
    OP_SUBTRACT_WITH_BORROW     = 4'h3,
    OP_OR                       = 4'h4,
    OP_AND                      = 4'h5,
    OP_XOR                      = 4'h6,
    OP_SKIP_IF_BITS_SET         = 4'h8,
    OP_SKIP_IF_BITS_CLEAR       = 4'h9,
    OP_SKIP_IF_EQUAL            = 4'hA,
    OP_SKIP_IF_NOT_EQUAL        = 4'hB,
    OP_SKIP_IF_GREATER_OR_EQUAL = 4'hC,
    OP_SKIP_IF_LESS             = 4'hD
  } op_type;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [11:0] spare;
    logic        to_reg;
    logic [6:0]  dest;
    logic [3:0]  operand_b;
    logic [3:0]  operand_a;
    op_type      op;
  } cmd_type;

  typedef struct packed {
    logic decimal;
    logic compare_only_flag;
    logic zero;
    logic carry_flag;
  } status_type;

endpackage : nibble_alu_pkg

// ==== rtl/alu_decimal_adjust.sv ====
// decimal adjustment of a binary nibble result with carry
`timescale 1ns/1ps
module alu_decimal_adjust
  import nibble_alu_pkg::*;
(
  input  wire logic       is_sub,
  input  wire logic       bin_carry,
  input  wire logic [3:0] bin_digit,
  output logic            dec_carry,
  output logic [3:0]      dec_digit
);

  // ------------------------------------------------------------
  // adjustment
  // ------------------------------------------------------------
  always_comb begin
    dec_carry = 1'b1;
    dec_digit = bin_digit | DEC_BAD_DIGIT;
    if (!is_sub) begin
      if (!bin_carry && bin_digit <= DEC_MAX_DIGIT) begin
        dec_carry = 1'b0;
        dec_digit = bin_digit;
      end else if (!bin_carry || bin_digit <= DEC_ADD_TOP) begin
        dec_digit = bin_digit + DEC_FIX;
      end
    end else begin
      if (!bin_carry && bin_digit <= DEC_MAX_DIGIT) begin
        dec_carry = 1'b0;
        dec_digit = bin_digit;
      end else if (bin_carry && bin_digit >= DEC_SUB_LOW) begin
        dec_digit = bin_digit - DEC_FIX;
      end
    end
  end

endmodule : alu_decimal_adjust

// ==== rtl/alu_skip_eval.sv ====
// skip decision for bit tests and immediate compares
`timescale 1ns/1ps
module alu_skip_eval
  import nibble_alu_pkg::*;
(
  input  wire op_type     op,
  input  wire logic [3:0] mem_nibble,
  input  wire logic [3:0] immediate_nibble,
  output logic            skip,
  output logic            is_test
);

  logic [3:0] all_set;
  logic [3:0] all_clear;

  // ------------------------------------------------------------
  // per-bit mask test
  // ------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_bit
    assign all_set[i]   = !immediate_nibble[i] || mem_nibble[i];
    assign all_clear[i] = !immediate_nibble[i] || !mem_nibble[i];
  end

  always_comb begin
    skip    = 1'b0;
    is_test = 1'b1;
    case (op)
      OP_SKIP_IF_BITS_SET:         skip = &all_set;
      OP_SKIP_IF_BITS_CLEAR:       skip = &all_clear;
      OP_SKIP_IF_EQUAL:            skip = mem_nibble == immediate_nibble;
      OP_SKIP_IF_NOT_EQUAL:        skip = mem_nibble != immediate_nibble;
      OP_SKIP_IF_GREATER_OR_EQUAL: skip = mem_nibble >= immediate_nibble;
      OP_SKIP_IF_LESS:             skip = mem_nibble < immediate_nibble;
      default:                     is_test = 1'b0;
    endcase
  end

endmodule : alu_skip_eval

// ==== rtl/nibble_alu_bcd_compare_skip.sv ====
// nibble ALU with binary/decimal arithmetic, logic ops and skip tests behind APB
//
// Overview of operation
// - binary mode, no compare-only: add or subtract in four bits, write result back.
// - binary carry set on overflow above 1111B or borrow below 0000B.
// - binary, compare-only off: zero set when result is 0000B, despite carry.
// - compare-only: add and subtract compute and update flags, but never write the result back.
// - compare-only: zero result keeps zero flag, nonzero result clears it.
// - decimal mode: store decimal result, carry above 1001B or below 0000B.
// - decimal, compare-only off: zero set when decimal result is 0000B.
// - decimal result comes from binary result plus carry through an adjust stage.
// - decimal results out of range give carry and a digit of 1010B or more.
// - stored arithmetic result aimed at status word overwrites the new flags.
// - OR, AND, XOR per truth table, result written to first operand.
// - logic ops ignore decimal and compare-only, always write, keep carry and zero unless aimed at status word.
// - bits-set test skips when every masked memory bit is one.
// - bits-clear test skips when every masked memory bit is zero.
// - bit tests ignore decimal, keep carry and zero, clear compare-only.
// - equal, not-equal, greater-or-equal, less compares skip when relation holds.
// - compares ignore decimal and compare-only, keep carry and zero.
// - a taken skip pulses SKIP_NEXT for one cycle; the next command written still executes.
// - stored results go to the first operand's register or memory address.
// - add-with-carry adds carry, subtract-with-borrow subtracts borrow held in carry.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
module nibble_alu_bcd_compare_skip
  import nibble_alu_pkg::*;
(
  input  wire logic              REF_CLK,
  input  wire logic              NRST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  output logic      [3:0]        RESULT_DATA,
  output logic      [6:0]        RESULT_ADDR,
  output logic                   RESULT_TO_REG,
  output logic                   RESULT_WE,
  output logic                   SKIP_NEXT
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  status_type  status_q,    status_d;
  logic [31:0] command_q,   command_d;
  logic [31:0] prdata_q,    prdata_d;
  logic        pready_q,    pready_d;
  logic        pslverr_q,   pslverr_d;
  logic [3:0]  result_q,    result_d;
  logic [6:0]  raddr_q,     raddr_d;
  logic        to_reg_q,    to_reg_d;
  logic        we_q,        we_d;
  logic        skip_q,      skip_d;

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  cmd_type     cmd_w;
  logic [9:0]  index_w;
  logic        mapped_w;
  logic        setup_w;
  logic        access_w;
  logic        fire_w;
  logic        status_wr_w;

  assign cmd_w       = cmd_type'(PWDATA);
  assign index_w     = PADDR[ADDR_W-1:2];
  assign mapped_w    = (index_w == IDX_COMMAND) || (index_w == IDX_RESULT) || (index_w == IDX_STATUS);
  assign setup_w     = PSEL && !PENABLE;
  assign access_w    = PSEL && PENABLE && pready_q;
  assign fire_w      = access_w && PWRITE && (index_w == IDX_COMMAND);
  assign status_wr_w = access_w && PWRITE && (index_w == IDX_STATUS);

  // ------------------------------------------------------------
  // datapath
  // ------------------------------------------------------------
  logic        is_add_w;
  logic        is_sub_w;
  logic        is_arith_w;
  logic        is_logic_w;
  logic        carry_in_w;
  logic [4:0]  bin5_w;
  logic [3:0]  dec_digit_w;
  logic        dec_carry_w;
  logic [3:0]  arith_digit_w;
  logic        arith_carry_w;
  logic [3:0]  logic_res_w;
  logic        skip_w;
  logic        is_test_w;

  assign is_add_w   = (cmd_w.op == OP_ADD) || (cmd_w.op == OP_ADD_WITH_CARRY);
  assign is_sub_w   = (cmd_w.op == OP_SUB) || (cmd_w.op == OP_SUBTRACT_WITH_BORROW);
  assign is_arith_w = is_add_w || is_sub_w;
  assign is_logic_w = (cmd_w.op == OP_OR) || (cmd_w.op == OP_AND) || (cmd_w.op == OP_XOR);
  // carry feeds in only for the with-carry forms
  assign carry_in_w = status_q.carry_flag &&
                      ((cmd_w.op == OP_ADD_WITH_CARRY) || (cmd_w.op == OP_SUBTRACT_WITH_BORROW));

  // five-bit result, bit 4 is carry or borrow
  assign bin5_w = is_sub_w ? ({1'b0, cmd_w.operand_a} - {1'b0, cmd_w.operand_b} - {4'h0, carry_in_w})
                           : ({1'b0, cmd_w.operand_a} + {1'b0, cmd_w.operand_b} + {4'h0, carry_in_w});

  alu_decimal_adjust u_adjust (
    .is_sub    (is_sub_w),
    .bin_carry (bin5_w[4]),
    .bin_digit (bin5_w[3:0]),
    .dec_carry (dec_carry_w),
    .dec_digit (dec_digit_w)
  );

  assign arith_digit_w = status_q.decimal ? dec_digit_w : bin5_w[3:0];
  assign arith_carry_w = status_q.decimal ? dec_carry_w : bin5_w[4];

  always_comb begin
    case (cmd_w.op)
      OP_OR:   logic_res_w = cmd_w.operand_a | cmd_w.operand_b;
      OP_AND:  logic_res_w = cmd_w.operand_a & cmd_w.operand_b;
      OP_XOR:  logic_res_w = cmd_w.operand_a ^ cmd_w.operand_b;
      default: logic_res_w = 4'h0;
    endcase
  end

  alu_skip_eval u_skip (
    .op               (cmd_w.op),
    .mem_nibble       (cmd_w.operand_a),
    .immediate_nibble (cmd_w.operand_b),
    .skip             (skip_w),
    .is_test          (is_test_w)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    status_d  = status_q;
    command_d = command_q;
    prdata_d  = prdata_q;
    pready_d  = 1'b0;
    pslverr_d = 1'b0;
    result_d  = result_q;
    raddr_d   = raddr_q;
    to_reg_d  = to_reg_q;
    we_d      = 1'b0;
    skip_d    = 1'b0;

    // no wait state: answer prepared in the setup cycle
    if (setup_w) begin
      pready_d  = 1'b1;
      pslverr_d = !mapped_w;
      case (index_w)
        IDX_COMMAND: prdata_d = command_q;
        IDX_RESULT:  prdata_d = {26'h0, skip_q, we_q, result_q};
        IDX_STATUS:  prdata_d = {28'h0, status_q};
        default:     prdata_d = 32'h0000_0000;
      endcase
    end

    if (status_wr_w) begin
      status_d = status_type'(PWDATA[3:0]);
    end

    if (fire_w) begin
      command_d = PWDATA;
      if (is_arith_w) begin
        status_d.carry_flag = arith_carry_w;
        if (status_q.compare_only_flag) begin
          // zero accumulates over chained compares
          if (arith_digit_w != 4'h0) begin
            status_d.zero = 1'b0;
          end
        end else begin
          status_d.zero = (arith_digit_w == 4'h0);
          result_d      = arith_digit_w;
          raddr_d       = cmd_w.dest;
          to_reg_d      = cmd_w.to_reg;
          we_d          = 1'b1;
          if (!cmd_w.to_reg && cmd_w.dest == STATUS_DATA_ADDR) begin
            status_d = status_type'(arith_digit_w);
          end
        end
      end else if (is_logic_w) begin
        // flags untouched whatever the mode bits say, unless the result is aimed at the status word
        result_d = logic_res_w;
        raddr_d  = cmd_w.dest;
        to_reg_d = cmd_w.to_reg;
        we_d     = 1'b1;
        if (!cmd_w.to_reg && cmd_w.dest == STATUS_DATA_ADDR) begin
          status_d = status_type'(logic_res_w);
        end
      end else if (is_test_w) begin
        skip_d = skip_w;
        if (cmd_w.op == OP_SKIP_IF_BITS_SET || cmd_w.op == OP_SKIP_IF_BITS_CLEAR) begin
          status_d.compare_only_flag = 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      status_q  <= status_type'(STATUS_RESET);
      command_q <= COMMAND_RESET;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      result_q  <= RESULT_RESET;
      raddr_q   <= 7'h00;
      to_reg_q  <= 1'b0;
      we_q      <= 1'b0;
      skip_q    <= 1'b0;
    end else begin
      status_q  <= status_d;
      command_q <= command_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      result_q  <= result_d;
      raddr_q   <= raddr_d;
      to_reg_q  <= to_reg_d;
      we_q      <= we_d;
      skip_q    <= skip_d;
    end
  end

  assign PRDATA        = prdata_q;
  assign PREADY        = pready_q;
  assign PSLVERR       = pslverr_q;
  assign RESULT_DATA   = result_q;
  assign RESULT_ADDR   = raddr_q;
  assign RESULT_TO_REG = to_reg_q;
  assign RESULT_WE     = we_q;
  assign SKIP_NEXT     = skip_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [4:0] chk_sum5;
  logic [3:0] chk_a;
  logic [3:0] chk_b;
  logic       chk_status_dest;
  logic [4:0] chk_sum_c5;

  assign chk_sum5        = {1'b0, cmd_w.operand_a} + {1'b0, cmd_w.operand_b};
  assign chk_a           = cmd_w.operand_a;
  assign chk_b           = cmd_w.operand_b;
  assign chk_status_dest = !cmd_w.to_reg && (cmd_w.dest == STATUS_DATA_ADDR);
  assign chk_sum_c5      = chk_sum5 + {4'h0, status_q.carry_flag};

  a_binary_carry: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && cmd_w.op == OP_ADD && !status_q.decimal && !chk_status_dest
    |=> status_q.carry_flag == ($past(chk_sum5) > 5'h0F))
    else $error("binary carry wrong");

  a_binary_zero: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && cmd_w.op == OP_ADD && !status_q.decimal && !status_q.compare_only_flag && !chk_status_dest
    |=> status_q.zero == ($past(chk_sum5[3:0]) == 4'h0) && RESULT_WE && RESULT_DATA == $past(chk_sum5[3:0]))
    else $error("binary zero or result wrong");

  a_compare_nowrite: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && is_arith_w && status_q.compare_only_flag
    |=> !RESULT_WE && $stable(RESULT_DATA))
    else $error("result written under compare-only");

  a_compare_zero: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && cmd_w.op == OP_SUB && !status_q.decimal && status_q.compare_only_flag
    |=> status_q.zero == ($past(status_q.zero) && $past(chk_a) == $past(chk_b)))
    else $error("zero accumulation wrong");

  a_decimal_carry: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && cmd_w.op == OP_ADD && status_q.decimal && !status_q.compare_only_flag
    && chk_sum5 <= 5'h13 && !chk_status_dest
    |=> status_q.carry_flag == ($past(chk_sum5) > 5'h09) && RESULT_DATA <= 4'h9)
    else $error("decimal carry wrong");

  a_decimal_range: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && cmd_w.op == OP_ADD && status_q.decimal && !status_q.compare_only_flag
    && chk_sum5 > 5'h13 && !chk_status_dest
    |=> status_q.carry_flag && RESULT_DATA >= 4'hA)
    else $error("decimal out-of-range marking wrong");

  a_status_over: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && cmd_w.op == OP_ADD && !status_q.decimal && !status_q.compare_only_flag && chk_status_dest
    |=> status_q == status_type'($past(chk_sum5[3:0])))
    else $error("status overwrite wrong");

  a_logic_flags: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && is_logic_w && !chk_status_dest
    |=> RESULT_WE && $stable(status_q))
    else $error("logic op touched flags or skipped write");

  a_bit_test: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && cmd_w.op == OP_SKIP_IF_BITS_SET
    |=> !status_q.compare_only_flag && $stable(status_q.carry_flag) && $stable(status_q.zero) && !RESULT_WE)
    else $error("bit test flag handling wrong");

  a_skip_less: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && cmd_w.op == OP_SKIP_IF_LESS
    |=> SKIP_NEXT == ($past(chk_a) < $past(chk_b)) && $stable(status_q))
    else $error("less compare wrong");

  a_skip_pulse: assert property (@(posedge REF_CLK) disable iff (!NRST)
    SKIP_NEXT |-> $past(fire_w) && $past(is_test_w) && !RESULT_WE)
    else $error("skip without test");

  a_decimal_zero: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && is_arith_w && status_q.decimal && !status_q.compare_only_flag && !chk_status_dest
    |=> RESULT_WE && status_q.zero == (RESULT_DATA == 4'h0))
    else $error("decimal zero wrong");

  a_carry_chain: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && cmd_w.op == OP_ADD_WITH_CARRY && !status_q.decimal && !chk_status_dest
    |=> status_q.carry_flag == ($past(chk_sum_c5) > 5'h0F))
    else $error("add with carry wrong");

  a_logic_xor: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && cmd_w.op == OP_XOR
    |=> RESULT_WE && RESULT_DATA == ($past(chk_a) ^ $past(chk_b)))
    else $error("xor result wrong");

  a_bits_set: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && cmd_w.op == OP_SKIP_IF_BITS_SET
    |=> SKIP_NEXT == (($past(chk_a) & $past(chk_b)) == $past(chk_b)))
    else $error("bits-set skip wrong");

  a_bits_clear: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && cmd_w.op == OP_SKIP_IF_BITS_CLEAR
    |=> SKIP_NEXT == (($past(chk_a) & $past(chk_b)) == 4'h0) && !status_q.compare_only_flag)
    else $error("bits-clear skip wrong");

  a_skip_equal: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && cmd_w.op == OP_SKIP_IF_EQUAL
    |=> SKIP_NEXT == ($past(chk_a) == $past(chk_b)))
    else $error("equal compare wrong");

  a_compare_flags: assert property (@(posedge REF_CLK) disable iff (!NRST)
    fire_w && (cmd_w.op == OP_SKIP_IF_EQUAL || cmd_w.op == OP_SKIP_IF_NOT_EQUAL
    || cmd_w.op == OP_SKIP_IF_GREATER_OR_EQUAL || cmd_w.op == OP_SKIP_IF_LESS)
    |=> $stable(status_q) && !RESULT_WE)
    else $error("compare touched flags");

endmodule : nibble_alu_bcd_compare_skip

// ==== tb/alu_mem_model.sv ====
// model of the data memory and register file receiving stored results and skips
`timescale 1ns/1ps
module alu_mem_model
  import nibble_alu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [3:0] data,
  input  wire logic [6:0] addr,
  input  wire logic       to_reg,
  input  wire logic       we,
  input  wire logic       skip,
  output int              n_we,
  output int              n_skip,
  output logic      [3:0] last_data,
  output logic      [6:0] last_addr,
  output logic            last_to_reg
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      n_we        <= 0;
      n_skip      <= 0;
      last_data   <= 4'h0;
      last_addr   <= 7'h00;
      last_to_reg <= 1'b0;
    end else begin
      // stored result lands at the first operand's location
      if (we === 1'b1) begin
        n_we        <= n_we + 1;
        last_data   <= data;
        last_addr   <= addr;
        last_to_reg <= to_reg;
      end
      // each skip pulse adds one to n_skip
      if (skip === 1'b1) begin
        n_skip <= n_skip + 1;
      end
    end
  end
endmodule : alu_mem_model

// ==== tb/tb.sv ====
// self-checking testbench of the nibble ALU against a behavioural model
`timescale 1ns/1ps
module tb;
  import nibble_alu_pkg::*;
  logic              REF_CLK, NRST, PSEL, PENABLE, PWRITE;
  logic [ADDR_W-1:0] PADDR;
  logic [31:0]       PWDATA, PRDATA;
  logic              PREADY, PSLVERR, RESULT_TO_REG, RESULT_WE, SKIP_NEXT;
  logic [3:0]        RESULT_DATA, last_data;
  logic [6:0]        RESULT_ADDR, last_addr;
  logic              last_to_reg;
  int                n_we, n_skip, n_mismatch, num_checks;
  logic [31:0]       seed;

  nibble_alu_bcd_compare_skip dut_u (.REF_CLK(REF_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .RESULT_DATA(RESULT_DATA), .RESULT_ADDR(RESULT_ADDR), .RESULT_TO_REG(RESULT_TO_REG),
    .RESULT_WE(RESULT_WE), .SKIP_NEXT(SKIP_NEXT));
  alu_mem_model mem_u (.clk(REF_CLK), .rst_n(NRST), .data(RESULT_DATA), .addr(RESULT_ADDR),
    .to_reg(RESULT_TO_REG), .we(RESULT_WE), .skip(SKIP_NEXT), .n_we(n_we), .n_skip(n_skip),
    .last_data(last_data), .last_addr(last_addr), .last_to_reg(last_to_reg));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 0, 1);
    r = PRDATA;
    e = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge REF_CLK);
  endtask : apb

  // expected effect of one command on the status word and the outputs
  task automatic model(input logic [31:0] c, inout logic [3:0] st, output logic we, output logic sk,
                       output logic [3:0] r);
    logic [3:0] a, b;
    int         s;
    logic       cy;
    a  = c[7:4];
    b  = c[11:8];
    we = 1'b0;
    sk = 1'b0;
    r  = 4'h0;
    case (c[3:0])
      4'h0, 4'h1, 4'h2, 4'h3: begin
        s  = c[1] ? a - b - (c[0] & st[0]) : a + b + (c[0] & st[0]);
        r  = s[3:0];
        cy = (s > 15) || (s < 0);
        if (st[3]) begin
          if (s >= 0 && s <= 9) cy = 1'b0;
          else if (c[1] ? (s >= -10 && s < 0) : (s <= 19)) begin
            r  = c[1] ? 4'(s + 10) : 4'(s - 10);
            cy = 1'b1;
          end else begin
            r  = s[3:0] | 4'hA;
            cy = 1'b1;
          end
        end
        st[1] = st[2] ? (st[1] && r == 4'h0) : (r == 4'h0);
        st[0] = cy;
        we    = !st[2];
      end
      4'h4, 4'h5, 4'h6: begin
        r  = (c[3:0] == 4'h4) ? (a | b) : (c[3:0] == 4'h5) ? (a & b) : (a ^ b);
        we = 1'b1;
      end
      4'h8, 4'h9: begin
        sk    = c[0] ? ((a & b) == 4'h0) : ((a & b) == b);
        st[2] = 1'b0;
      end
      4'hA: sk = (a == b);
      4'hB: sk = (a != b);
      4'hC: sk = (a >= b);
      4'hD: sk = (a < b);
      default: ;
    endcase
    if (we && !c[19] && c[18:12] == STATUS_DATA_ADDR) st = r;
  endtask : model

  // ------------------------------------------------------------
  // clock, watchdog, main sequence
  // ------------------------------------------------------------
  initial begin
    REF_CLK = 1'b0;
    forever #2.5 REF_CLK = ~REF_CLK;
  end

  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    logic [31:0] rd, c, x;
    logic        e, we, sk;
    logic [3:0]  st, r, lr;
    int          w0, s0;
    NRST = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = '0; PWDATA = '0;
    n_mismatch = 0; num_checks = 0; seed = 32'h3FDB;
    lr = RESULT_RESET;
    repeat (4) @(posedge REF_CLK);
    NRST <= 1'b1;
    @(posedge REF_CLK);
    apb(1'b0, {IDX_STATUS, 2'b00}, 32'h0, rd, e);
    chk("status reset", rd, {28'h0, STATUS_RESET});
    apb(1'b0, {IDX_COMMAND, 2'b00}, 32'h0, rd, e);
    chk("command reset", rd, COMMAND_RESET);
    apb(1'b0, 12'h100, 32'h0, rd, e);
    chk("unmapped err", e, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, {IDX_STATUS, 2'b00}, 32'hFFFF_FFF5, rd, e);
    apb(1'b0, {IDX_STATUS, 2'b00}, 32'h0, rd, e);
    chk("status rw", rd, 32'h5);
    for (int i = 0; i < 400; i++) begin
      x  = xs();
      st = x[3:0];
      c  = xs();
      if (c[22:20] == 3'h0) c[19:12] = {1'b0, STATUS_DATA_ADDR};
      // decimal operands unrestricted: in-range and out-of-range both occur
      x  = xs();
      apb(1'b1, {IDX_STATUS, 2'b00}, {x[31:4], st}, rd, e);
      w0 = n_we;
      s0 = n_skip;
      apb(1'b1, {IDX_COMMAND, 2'b00}, c, rd, e);
      model(c, st, we, sk, r);
      repeat (3) @(posedge REF_CLK);
      chk("store count", 32'(n_we - w0), {31'h0, we});
      chk("skip count", 32'(n_skip - s0), {31'h0, sk});
      if (we) begin
        chk("result", last_data, r);
        chk("dest", {last_to_reg, last_addr}, c[19:12]);
        lr = r;
      end
      apb(1'b0, {IDX_STATUS, 2'b00}, 32'h0, rd, e);
      chk("status", rd, {28'h0, st});
      apb(1'b0, {IDX_RESULT, 2'b00}, 32'h0, rd, e);
      chk("result reg", rd, {28'h0, lr});
    end
    // second reset after the command loop
    NRST <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    NRST <= 1'b1;
    @(posedge REF_CLK);
    apb(1'b0, {IDX_STATUS, 2'b00}, 32'h0, rd, e);
    chk("status rerst", rd, {28'h0, STATUS_RESET});
    apb(1'b0, {IDX_RESULT, 2'b00}, 32'h0, rd, e);
    chk("result rerst", rd, {28'h0, RESULT_RESET});
    end_of_test();
  end
endmodule : tb
